// >>> design/usdb_top.v
// shadow receive/transmit data port of a uart with serial and infrared lines
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "usdb_map.vh"
module usdb_top #(
	parameter DEPTH = `USDB_FIFO_DEPTH,
	parameter AW = 4,
	parameter BIT_CYC = `USDB_BIT_CYC
) (
	input  wire        sys_clk,
	input  wire        nrst,
	input  wire [31:0] addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire        serial_in,
	input  wire        ir_in,
	output reg         serial_out,
	output reg         ir_out_n,
	output reg         irq
);
	localparam [15:0] BITC = BIT_CYC[15:0];
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_START = 4'b0010;
	localparam [3:0] S_DATA = 4'b0100;
	localparam [3:0] S_STOP = 4'b1000;
	reg  [1:0]  ctrl;
	reg  [3:0]  isr;
	reg  [3:0]  imr;
	reg         overrun;
	reg  [7:0]  rx_hold;
	reg         rx_hold_valid;
	reg  [7:0]  tx_hold;
	reg         tx_hold_full;
	reg  [3:0]  rx_state;
	reg  [15:0] rx_cnt;
	reg  [2:0]  rx_bit;
	reg  [7:0]  rx_shift;
	reg         rx_done;
	reg  [7:0]  rx_byte;
	reg  [3:0]  tx_state;
	reg  [15:0] tx_cnt;
	reg  [2:0]  tx_bit;
	reg  [7:0]  tx_shift;
	reg         tx_line;
	reg         rx_s1;
	reg         rx_s2;
	reg         tx_holding_empty_flag_prev;
	wire        fifo_en;
	wire        ir_mode;
	wire        rx_line;
	wire        shadow_hit;
	wire        data_rd;
	wire        data_wr;
	wire [7:0]  rxf_head;
	wire        rxf_full;
	wire        rxf_empty;
	wire [7:0]  txf_head;
	wire        txf_full;
	wire        txf_empty;
	wire        data_ready;
	wire        tx_holding_empty_flag;
	wire        tx_have;
	wire        tx_take;
	wire        rx_drop;
	wire        tx_lost;
	wire [3:0]  next_isr;
	wire [7:0]  line_status_reg;
	assign fifo_en = ctrl[`USDB_CTRL_FIFO_EN];
	assign ir_mode = ctrl[`USDB_CTRL_IR_MODE];
	assign rx_line = rx_s2;
	assign shadow_hit = (addr >= `USDB_SHADOW_BASE) && (addr <= `USDB_SHADOW_TOP)
		&& (addr[1:0] == 2'b00);
	assign data_rd = rd && shadow_hit;
	assign data_wr = wr && shadow_hit;
	assign data_ready = fifo_en ? !rxf_empty : rx_hold_valid;
	assign tx_holding_empty_flag = fifo_en ? !txf_full && txf_empty : !tx_hold_full;
	assign tx_have = fifo_en ? !txf_empty : tx_hold_full;
	assign tx_take = (tx_state == S_IDLE) && tx_have;
	assign rx_drop = rx_done && (fifo_en ? rxf_full : rx_hold_valid && !data_rd);
	assign tx_lost = data_wr && fifo_en && txf_full;
	assign line_status_reg = {1'b0, tx_state == S_IDLE && !tx_have, tx_holding_empty_flag, 3'b000, overrun, data_ready};
	assign next_isr = {tx_lost, tx_holding_empty_flag && !tx_holding_empty_flag_prev, rx_drop, rx_done};
	usdb_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_rxf (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.clr       (!fifo_en),
		.push      (rx_done && fifo_en),
		.push_data (rx_byte),
		.pop       (data_rd && fifo_en),
		.head      (rxf_head),
		.full      (rxf_full),
		.empty     (rxf_empty)
	);
	usdb_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_txf (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.clr       (!fifo_en),
		.push      (data_wr && fifo_en),
		.push_data (wdata[7:0]),
		.pop       (tx_take && fifo_en),
		.head      (txf_head),
		.full      (txf_full),
		.empty     (txf_empty)
	);
	// registers, read data and interrupt
	always @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl <= 2'b00;
			imr <= 4'h0;
			isr <= 4'h0;
			overrun <= 1'b0;
			rdata <= 32'h0000_0000;
			irq <= 1'b0;
			tx_holding_empty_flag_prev <= 1'b1;
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			// both lines idle high, so the infrared level needs no inversion
			rx_s1 <= ir_mode ? ir_in : serial_in;
			rx_s2 <= rx_s1;
			tx_holding_empty_flag_prev <= tx_holding_empty_flag;
			if (wr && addr == `USDB_CTRL_OFS) begin
				ctrl <= wdata[1:0];
			end
			if (wr && addr == `USDB_IMR_OFS) begin
				imr <= wdata[3:0];
			end
			// set wins over the read-clear
			if (rd && addr == `USDB_ISR_OFS) begin
				isr <= next_isr;
			end else begin
				isr <= isr | next_isr;
			end
			if (rx_drop) begin
				overrun <= 1'b1;
			end else if (rd && addr == `USDB_LSR_OFS) begin
				overrun <= 1'b0;
			end
			irq <= |(((rd && addr == `USDB_ISR_OFS) ? next_isr : (isr | next_isr)) & imr);
			rdata <= 32'h0000_0000;
			if (data_rd) begin
				rdata <= {24'h00_0000, fifo_en ? rxf_head : rx_hold};
			end else if (rd && addr == `USDB_CTRL_OFS) begin
				rdata <= {30'h0000_0000, ctrl};
			end else if (rd && addr == `USDB_LSR_OFS) begin
				rdata <= {24'h00_0000, line_status_reg};
			end else if (rd && addr == `USDB_ISR_OFS) begin
				rdata <= {28'h000_0000, isr};
			end else if (rd && addr == `USDB_IMR_OFS) begin
				rdata <= {28'h000_0000, imr};
			end
		end
	end
	// non-fifo holding registers
	always @(posedge sys_clk) begin
		if (!nrst || fifo_en) begin
			rx_hold <= 8'h00;
			rx_hold_valid <= 1'b0;
			tx_hold <= 8'h00;
			tx_hold_full <= 1'b0;
		end else begin
			if (rx_done) begin
				rx_hold <= rx_byte;
				rx_hold_valid <= 1'b1;
			end else if (data_rd) begin
				rx_hold_valid <= 1'b0;
			end
			if (data_wr) begin
				tx_hold <= wdata[7:0];
				tx_hold_full <= 1'b1;
			end else if (tx_take) begin
				tx_hold_full <= 1'b0;
			end
		end
	end
	// receiver: 8n1, mid-bit sampling
	always @(posedge sys_clk) begin
		if (!nrst) begin
			rx_state <= S_IDLE;
			rx_cnt <= 16'h0000;
			rx_bit <= 3'd0;
			rx_shift <= 8'h00;
			rx_done <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			rx_done <= 1'b0;
			case (rx_state)
				S_IDLE: begin
					if (!rx_line) begin
						rx_cnt <= {1'b0, BITC[15:1]};
						rx_state <= S_START;
					end
				end
				S_START: begin
					if (rx_cnt != 16'h0000) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else if (rx_line) begin
						rx_state <= S_IDLE;
					end else begin
						rx_cnt <= BITC - 1'b1;
						rx_bit <= 3'd0;
						rx_state <= S_DATA;
					end
				end
				S_DATA: begin
					if (rx_cnt != 16'h0000) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						rx_shift <= {rx_line, rx_shift[7:1]};
						rx_cnt <= BITC - 1'b1;
						rx_bit <= rx_bit + 1'b1;
						if (rx_bit == 3'd7) begin
							rx_state <= S_STOP;
						end
					end
				end
				S_STOP: begin
					if (rx_cnt != 16'h0000) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						rx_byte <= rx_shift;
						rx_done <= rx_line;
						rx_state <= S_IDLE;
					end
				end
				default: begin
					rx_state <= S_IDLE;
				end
			endcase
		end
	end
	// transmitter; infrared pulse shaping is left out, ir_out_n carries the line level without inversion
	always @(posedge sys_clk) begin
		if (!nrst) begin
			tx_state <= S_IDLE;
			tx_cnt <= 16'h0000;
			tx_bit <= 3'd0;
			tx_shift <= 8'h00;
			tx_line <= 1'b1;
			serial_out <= 1'b1;
			ir_out_n <= 1'b1;
		end else begin
			serial_out <= ir_mode ? 1'b1 : tx_line;
			ir_out_n <= ir_mode ? tx_line : 1'b1;
			case (tx_state)
				S_IDLE: begin
					tx_line <= 1'b1;
					if (tx_take) begin
						tx_shift <= fifo_en ? txf_head : tx_hold;
						tx_cnt <= BITC - 1'b1;
						tx_line <= 1'b0;
						tx_state <= S_START;
					end
				end
				S_START: begin
					if (tx_cnt != 16'h0000) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else begin
						tx_cnt <= BITC - 1'b1;
						tx_line <= tx_shift[0];
						tx_bit <= 3'd0;
						tx_state <= S_DATA;
					end
				end
				S_DATA: begin
					if (tx_cnt != 16'h0000) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else begin
						tx_cnt <= BITC - 1'b1;
						tx_shift <= {1'b1, tx_shift[7:1]};
						tx_bit <= tx_bit + 1'b1;
						tx_line <= (tx_bit == 3'd7) ? 1'b1 : tx_shift[1];
						if (tx_bit == 3'd7) begin
							tx_state <= S_STOP;
						end
					end
				end
				S_STOP: begin
					if (tx_cnt != 16'h0000) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else begin
						tx_state <= S_IDLE;
					end
				end
				default: begin
					tx_state <= S_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> common/usdb_map.vh
// register offsets, field positions, reset values and timing counts for the shadow data buffer
`ifndef USDB_MAP_VH
`define USDB_MAP_VH
`define USDB_ADDR_W          32
`define USDB_SHADOW_SLOT11   32'h5000_105c
`define USDB_SHADOW_BASE     32'h5000_1030
`define USDB_SHADOW_TOP      32'h5000_106c
`define USDB_CTRL_OFS        32'h5000_1100
`define USDB_LSR_OFS         32'h5000_1104
`define USDB_ISR_OFS         32'h5000_1108
`define USDB_IMR_OFS         32'h5000_110c
`define USDB_CTRL_FIFO_EN    0
`define USDB_CTRL_IR_MODE    1
`define USDB_LSR_DR          0
`define USDB_LSR_OE          1
`define USDB_LSR_TX_HOLDING_EMPTY_FLAG        5
`define USDB_LSR_TEMT        6
`define USDB_EV_RX           0
`define USDB_EV_OVR          1
`define USDB_EV_TX_HOLDING_EMPTY_FLAG         2
`define USDB_EV_TXLOST       3
`define USDB_RESET_DATA      16'h0000
`define USDB_BAUD_NS         26042
`define USDB_CLK_NS          25
`define USDB_BIT_CYC         ((`USDB_BAUD_NS + `USDB_CLK_NS - 1) / `USDB_CLK_NS)
`define USDB_FIFO_DEPTH      16
`endif

// >>> design/usdb_fifo.v
// byte fifo with push/pop, full/empty and head output
`timescale 1ns/1ps
`default_nettype none
module usdb_fifo #(
	parameter W = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input  wire         sys_clk,
	input  wire         nrst,
	input  wire         clr,
	input  wire         push,
	input  wire [W-1:0] push_data,
	input  wire         pop,
	output wire [W-1:0] head,
	output wire         full,
	output wire         empty
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] rd_ptr;
	reg [AW-1:0] wr_ptr;
	reg [AW:0]   count;
	wire do_push;
	wire do_pop;
	assign full = (count == DEPTH[AW:0]);
	assign empty = (count == {(AW+1){1'b0}});
	assign head = mem[rd_ptr];
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	always @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end
	always @(posedge sys_clk) begin
		if (!nrst || clr) begin
			rd_ptr <= {AW{1'b0}};
			wr_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1 && DEPTH < (1 << AW)) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1 && DEPTH < (1 << AW)) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				count <= count + 1'b1;
			end else if (do_pop && !do_push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/usdb_properties.sv
// port checker for the shadow data buffer
`timescale 1ns/1ps
`default_nettype none
`include "usdb_map.vh"
module usdb_chk #(parameter BIT_CYC = 8) (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        serial_out,
	input wire logic        ir_out_n,
	input wire logic        irq
);
	logic [3:0] msk;
	logic       irm;
	logic [15:0] lowc;
	logic       shd;
	logic       mapd;
	assign shd = addr >= `USDB_SHADOW_BASE && addr <= `USDB_SHADOW_TOP && addr[1:0] == 2'b00;
	assign mapd = shd || addr == `USDB_CTRL_OFS || addr == `USDB_LSR_OFS || addr == `USDB_ISR_OFS
		|| addr == `USDB_IMR_OFS;
	// mirrors of mask and mode, so the checks need no view inside
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			msk <= 4'h0;
			irm <= 1'b0;
			lowc <= 16'h0000;
		end else begin
			if (wr && addr == `USDB_IMR_OFS)
				msk <= wdata[3:0];
			if (wr && addr == `USDB_CTRL_OFS)
				irm <= wdata[`USDB_CTRL_IR_MODE];
			lowc <= serial_out ? 16'h0000 : lowc + 16'h0001;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_ir_bit; (!ir_out_n)[*8]; endsequence
	property p_rdata_idle; !$past(rd) |-> rdata == 32'h0000_0000; endproperty
	property p_rdata_hi; rd && shd |=> rdata[31:8] == 24'h00_0000; endproperty
	property p_unmapped; rd && !mapd |=> rdata == 32'h0000_0000; endproperty
	property p_tx_run; $rose(serial_out) |-> lowc != 16'h0000 && lowc % BIT_CYC == 0; endproperty
	property p_ir_bit; $fell(ir_out_n) |-> s_ir_bit; endproperty
	property p_irq_masked; msk == 4'h0 && $past(msk) == 4'h0 |-> !irq; endproperty
	property p_ir_ser; irm && $past(irm) |-> serial_out; endproperty
	property p_uart_ir; !irm && !$past(irm) |-> ir_out_n; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero outside read");
	a_rdata_hi: assert property (p_rdata_hi) else $error("upper data bits set");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	a_tx_run: assert property (p_tx_run) else $error("serial low run not whole bits");
	a_ir_bit: assert property (p_ir_bit) else $error("ir bit too short");
	a_irq_masked: assert property (p_irq_masked) else $error("irq with mask clear");
	a_ir_ser: assert property (p_ir_ser) else $error("serial out low in ir mode");
	a_uart_ir: assert property (p_uart_ir) else $error("ir out low in uart mode");
endmodule
bind usdb_top usdb_chk #(.BIT_CYC(BIT_CYC)) usdb_chk_i (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_out(serial_out), .ir_out_n(ir_out_n), .irq(irq));
`default_nettype wire

// >>> dv/usdb_line_model.sv
// far-side serial partner: sends 8n1 frames and collects sent bytes
`timescale 1ns/1ps
`default_nettype none
module usdb_line_model #(parameter BIT_CYC = 8) (
	input  wire logic sys_clk,
	output var  logic serial_in,
	output var  logic ir_in,
	input  wire logic serial_out,
	input  wire logic ir_out_n
);
	logic [7:0] rxq[$];
	logic [7:0] sh;
	initial begin
		serial_in = 1'b1;
		ir_in = 1'b1;
	end
	// lsb first; the unused line stays idle high
	task automatic send(input logic [7:0] b, input logic ir);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			if (ir)
				ir_in <= f[i];
			else
				serial_in <= f[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
	endtask
	// both outputs idle high, so the and follows whichever is live
	initial forever begin
		@(negedge (serial_out & ir_out_n));
		repeat (BIT_CYC / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge sys_clk);
			sh[i] = serial_out & ir_out_n;
		end
		repeat (BIT_CYC) @(posedge sys_clk);
		rxq.push_back(sh);
	end
endmodule
`default_nettype wire

// >>> dv/usdb_top_tb_top.sv
// testbench for the shadow data buffer
`timescale 1ns/1ps
`default_nettype none
`include "usdb_map.vh"
module usdb_top_tb_top;
	localparam int BC = 8;
	localparam int DP = 4;
	logic        sys_clk, nrst, wr, rd;
	logic [31:0] addr, wdata, rdata, d;
	wire logic   serial_in, ir_in, serial_out, ir_out_n, irq;
	int          miscompares, tests_run;
	usdb_top #(.DEPTH(DP), .AW(2), .BIT_CYC(BC)) usdb_top_i (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_in(serial_in), .ir_in(ir_in),
		.serial_out(serial_out), .ir_out_n(ir_out_n), .irq(irq));
	usdb_line_model #(.BIT_CYC(BC)) usdb_line_model_i (.sys_clk(sys_clk), .serial_in(serial_in),
		.ir_in(ir_in), .serial_out(serial_out), .ir_out_n(ir_out_n));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic bw(input logic [31:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic br(input logic [31:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// frame plus margin for the two-flop input sync
	task automatic rx(input logic [7:0] b, input logic ir);
		usdb_line_model_i.send(b, ir);
		repeat (BC) @(posedge sys_clk);
	endtask
	task automatic wait_tx(input int n);
		int k;
		for (k = 0; k < 4000 && usdb_line_model_i.rxq.size() < n; k++)
			@(posedge sys_clk);
		if (k == 4000) begin
			miscompares++;
			finish_test();
		end
		repeat (12 * BC) @(posedge sys_clk);
	endtask
	task automatic t_rx_off;
		@(negedge sys_clk);
		check({serial_out, ir_out_n, irq}, 3'b110);
		check(rdata, 32'h0000_0000);
		br(`USDB_SHADOW_SLOT11);
		check(d, 32'h0000_0000);
		rx(8'ha5, 1'b0);
		br(`USDB_LSR_OFS);
		check(d[0], 1'b1);
		br(`USDB_SHADOW_SLOT11);
		check(d, 32'h0000_00a5);
		br(`USDB_LSR_OFS);
		check(d[0], 1'b0);
		rx(8'h3c, 1'b0);
		rx(8'hc3, 1'b0);
		br(`USDB_LSR_OFS);
		check(d[1:0], 2'b11);
		br(`USDB_SHADOW_SLOT11);
		check(d, 32'h0000_00c3);
		br(32'h5000_1200);
		check(d, 32'h0000_0000);
	endtask
	task automatic t_rx_fifo;
		bw(`USDB_CTRL_OFS, 32'h0000_0001);
		for (int i = 0; i <= DP; i++)
			rx(8'h10 + i[7:0], 1'b0);
		br(`USDB_LSR_OFS);
		check(d[1:0], 2'b11);
		for (int i = 0; i < DP; i++) begin
			br(`USDB_SHADOW_BASE + 4 * i);
			check(d, 32'h0000_0010 + i);
		end
		br(`USDB_LSR_OFS);
		check(d[0], 1'b0);
		bw(`USDB_CTRL_OFS, 32'h0000_0002);
		rx(8'h5a, 1'b1);
		br(`USDB_SHADOW_SLOT11);
		check(d, 32'h0000_005a);
	endtask
	// third write lands while the holding byte is pending, so it replaces it
	task automatic t_tx_off;
		bw(`USDB_CTRL_OFS, 32'h0000_0000);
		usdb_line_model_i.rxq.delete();
		bw(`USDB_SHADOW_SLOT11, 32'h0000_0011);
		repeat (4) @(posedge sys_clk);
		br(`USDB_LSR_OFS);
		check(d[5], 1'b1);
		bw(`USDB_SHADOW_SLOT11, 32'h0000_0022);
		br(`USDB_LSR_OFS);
		check(d[5], 1'b0);
		bw(`USDB_SHADOW_SLOT11, 32'h0000_0033);
		wait_tx(2);
		check({usdb_line_model_i.rxq[0], usdb_line_model_i.rxq[1]}, 16'h1133);
		check(usdb_line_model_i.rxq.size(), 2);
	endtask
	task automatic t_tx_fifo;
		bw(`USDB_CTRL_OFS, 32'h0000_0001);
		usdb_line_model_i.rxq.delete();
		for (int i = 0; i < DP + 2; i++)
			bw(`USDB_SHADOW_SLOT11, 32'h0000_0040 + i);
		br(`USDB_ISR_OFS);
		check(d[3], 1'b1);
		// one byte goes straight to the shifter, the fifo holds the next DP, the last is lost
		wait_tx(DP + 1);
		for (int i = 0; i <= DP; i++)
			check(usdb_line_model_i.rxq[i], 8'h40 + i[7:0]);
		check(usdb_line_model_i.rxq.size(), DP + 1);
		bw(`USDB_CTRL_OFS, 32'h0000_0002);
		usdb_line_model_i.rxq.delete();
		bw(`USDB_SHADOW_SLOT11, 32'h0000_0096);
		wait_tx(1);
		check(usdb_line_model_i.rxq[0], 8'h96);
	endtask
	task automatic t_irq;
		bw(`USDB_CTRL_OFS, 32'h0000_0000);
		br(`USDB_ISR_OFS);
		bw(`USDB_IMR_OFS, 32'h0000_0001);
		rx(8'h77, 1'b0);
		check(irq, 1'b1);
		bw(`USDB_IMR_OFS, 32'h0000_0000);
		repeat (2) @(posedge sys_clk);
		check(irq, 1'b0);
		bw(`USDB_IMR_OFS, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		check(irq, 1'b1);
		br(`USDB_ISR_OFS);
		check(d[0], 1'b1);
		repeat (2) @(posedge sys_clk);
		check(irq, 1'b0);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		{nrst, wr, rd, addr, wdata, miscompares, tests_run} = '0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		t_rx_off();
		t_rx_fifo();
		t_tx_off();
		t_tx_fifo();
		t_irq();
		finish_test();
	end
endmodule
`default_nettype wire
